// [testbench/read_channel_model.sv]
`timescale 1ns/100ps
module read_channel_model (
  // Clock
  input  wire logic        clk,
  // Half periods in clocks: osc, ref, vco; zero parks a line low
  input  wire logic [11:0] halves,
  input  wire logic        data_req,
  // Pins toward the block
  output logic             raw_read_data,
  output logic             osc_3x_pulse,
  output logic             code_ref_pulse,
  output logic             synth_osc_pulse
);
  int         cnt [3];
  logic [2:0] wave;

  // Quiet start so no edge is seen before the bench asks
  initial begin
    cnt = '{0, 0, 0};
    wave = 3'h0;
    raw_read_data = 1'b0;
  end

  // Square waves; a parked line goes low rather than keep its last level
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (halves[4*i +: 4] == 4'h0) begin
        cnt[i] <= 0;
        wave[i] <= 1'b0;
      end else if (cnt[i] + 1 >= halves[4*i +: 4]) begin
        cnt[i] <= 0;
        wave[i] <= ~wave[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
    raw_read_data <= data_req;
  end

  assign osc_3x_pulse    = wave[0];
  assign code_ref_pulse  = wave[1];
  assign synth_osc_pulse = wave[2];
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/100ps
module tb_top
  import dsync_pkg::*;
;
  localparam int MON = 1 << WINDOW_MONITOR_ENABLE_BIT;
  localparam int PEN = 1 << PWS_EN_BIT;
  localparam int SEN = 1 << WSS_EN_BIT;
  // Bench drive
  logic        clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic        up_err, down_err, acquiring, data_req;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v, d;
  logic [3:0]  wstrb;
  logic [11:0] halves;
  // Block outputs and model pins
  logic        awready, wready, bvalid, arready, rvalid, raw_rd, osc, cref, sosc;
  logic [1:0]  bresp, rresp, band, r;
  logic        gain_half, res_bypass, pump_up, pump_dn, rec_clk, del_rd, win_clk, prev;
  int          seed, error_cnt, checked, n, base, lat, edges;
  int          off [4] = '{-1, 1, -2, 2};
  logic [7:0]  ofs [6];

  data_sync_window_shift_control data_sync_window_shift_control_inst (
    .clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .raw_read_data(raw_rd), .osc_3x_pulse(osc), .code_ref_pulse(cref),
    .synth_osc_pulse(sosc), .freq_up_err(up_err), .freq_down_err(down_err),
    .acquiring(acquiring), .loop_gain_band(band), .pd_gain_half(gain_half),
    .filter_res_bypass(res_bypass), .synth_pump_up(pump_up), .synth_pump_down(pump_dn),
    .recovered_clock(rec_clk), .delayed_read_data(del_rd), .detect_window_clock(win_clk)
  );

  read_channel_model read_channel_model_inst (
    .clk(clk), .halves(halves), .data_req(data_req), .raw_read_data(raw_rd),
    .osc_3x_pulse(osc), .code_ref_pulse(cref), .synth_osc_pulse(sosc)
  );

  // 40 MHz
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic stop_test;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A spent wait bound is a mismatch and ends the run
  task automatic tmo(input int k);
    if (k >= 200) begin
      chk(32'(k), 32'h0);
      stop_test();
    end
  endtask

  // Settle, then sample mid-cycle to stay clear of edge races
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  // Handshakes judged at the falling edge, acted on at the next rising one
  task automatic axw(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rr);
    int  k;
    logic ta, tw, tb;
    k = 0;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rr = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      k++;
      tmo(k);
    end
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rr);
    int  k;
    logic ta, tr;
    k = 0;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      dd = rdata;
      rr = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      k++;
      tmo(k);
    end
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    axw(a, dd, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axr(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // Cycles from a one-cycle raw pulse to the monitored data edge
  task automatic data_lat(output int l);
    @(posedge clk);
    data_req <= 1'b1;
    @(posedge clk);
    data_req <= 1'b0;
    l = 0;
    do begin
      @(negedge clk);
      l++;
      tmo(l);
    end while (del_rd !== 1'b1);
    repeat (30) @(posedge clk);
  endtask

  // Cycles from a recovered pulse to the next window pulse
  task automatic win_lat(output int l);
    int k;
    k = 0;
    l = 0;
    do begin
      @(negedge clk);
      k++;
      tmo(k);
    end while (rec_clk !== 1'b1);
    do begin
      @(negedge clk);
      l++;
      tmo(l);
    end while (win_clk !== 1'b1);
  endtask

  initial begin
    seed = 23;
    error_cnt = 0;
    checked = 0;
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {up_err, down_err, acquiring, data_req} = 4'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    halves = 12'h008;
    ofs = '{CONFIG_OFS, TEST_OFS, REF_DIV_OFS, OSC_DIV_OFS, AMP_OFS, STATUS_OFS};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, then unmapped and read-only places
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    axr(8'h18, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axw(8'h18, 32'hFFFFFFFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(STATUS_OFS, 32'hFFFFFFFF);
    rd(STATUS_OFS, 32'h0);
    // Field widths: all-ones written, only the field comes back
    wr(REF_DIV_OFS, 32'hFFFFFFFF);
    rd(REF_DIV_OFS, 32'h0000000F);
    wr(OSC_DIV_OFS, 32'hFFFFFFFF);
    rd(OSC_DIV_OFS, 32'h0000001F);
    wr(AMP_OFS, 32'hFFFFFFFF);
    rd(AMP_OFS, 32'h0000000F);
    // Random config words; the first four walk every band code
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      if (i < 4) v[1:0] = i[1:0];
      wr(CONFIG_OFS, v);
      rd(CONFIG_OFS, v & 32'h7F);
      idle(3);
      chk({30'h0, band}, {30'h0, v[1:0]});
    end
    // Acquisition then tracking
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk);
      acquiring <= i[0];
      idle(3);
      chk({31'h0, gain_half}, 32'(i));
      chk({31'h0, res_bypass}, 32'(i));
      rd(STATUS_OFS, 32'(i << 3));
    end
    // Monitor off: both pins low even with pulses, window and mux test live
    wr(CONFIG_OFS, 32'h0);
    wr(TEST_OFS, 32'h1);
    @(posedge clk);
    up_err <= 1'b1;
    down_err <= 1'b1;
    data_req <= 1'b1;
    @(posedge clk);
    data_req <= 1'b0;
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (del_rd !== 1'b0 || win_clk !== 1'b0) n++;
    end
    chk(32'(n), 32'h0);
    // Mux test with monitor on: every error combination
    wr(CONFIG_OFS, 32'(MON));
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      up_err <= i[0];
      down_err <= i[1];
      idle(6);
      chk({31'h0, del_rd}, 32'(i & 1));
      chk({31'h0, win_clk}, 32'(i >> 1));
    end
    wr(TEST_OFS, 32'h0);
    // Oscillator ticks between two recovered pulses
    win_lat(lat);
    edges = 0;
    n = 0;
    prev = osc;
    do begin
      @(negedge clk);
      if (osc && !prev) edges++;
      prev = osc;
      n++;
      tmo(n);
    end while (rec_clk !== 1'b1);
    chk(32'(edges), 32'h3);
    // Percent shift against the centre tap, synth shift running as well
    data_lat(base);
    wr(CONFIG_OFS, 32'(MON | 3 << PWS_DIR_BIT));
    data_lat(lat);
    chk(32'(lat - base), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(CONFIG_OFS, 32'(MON | PEN | i << PWS_DIR_BIT | SEN));
      data_lat(lat);
      chk(32'(lat - base), 32'(off[i]));
    end
    // Divider load only with synth off; ratios 2 and 3 as N minus one
    wr(CONFIG_OFS, 32'(MON));
    wr(REF_DIV_OFS, 32'h1);
    wr(OSC_DIV_OFS, 32'h2);
    // Base window delay taken with the largest amplifier value but synth off
    win_lat(base);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'hF : 32'($random(seed) & 15);
      wr(AMP_OFS, v);
      wr(CONFIG_OFS, 32'(MON | SEN));
      win_lat(lat);
      chk(32'(lat - base), v);
      wr(CONFIG_OFS, 32'(MON));
    end
    // One divided input alone drives one pump flag only
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      halves <= (i == 0) ? 12'h038 : 12'h208;
      wr(CONFIG_OFS, 32'(SEN));
      idle(60);
      chk({30'h0, pump_dn, pump_up}, 32'(1 << i));
      rd(STATUS_OFS, 32'(2 << i));
      wr(CONFIG_OFS, 32'h0);
    end
    rd(STATUS_OFS, 32'h0);
    stop_test();
  end
endmodule

// [verilog/data_sync_window_shift_control.sv]
// Contract
// [R1] Oscillator runs at 3x data rate, divided by three into recovered clock.
// [R2] Two-bit band field picks loop gain and filter setting.
// [R3] Acquisition halves detector gain and shorts filter resistor; tracking restores.
// [R4] Monitor outputs driven only with monitor enable set, else held low.
// [R5] Mux test puts frequency-up on data pin, frequency-down on window pin.
// [R6] Percent shift code: early/late by 6.25% or 12.5% of window.
// [R7] Percent shift and synthesized shift may act together.
// [R8] Synthesized window shift applies only while synth enable is set.
// [R9] Reference and oscillator dividers feed a phase-frequency lock detector.
// [R10] Software clears synth enable before loading dividers, then re-enables.
// [R11] Shift amplifier chains one to sixteen delay stages by select value.
// [R12] Software keeps per-stage delay 2ns to 6ns, total 2ns to 96ns.
// [R13] Software sets both divided frequencies equal, within 3 to 15 MHz.
// [R14] Divide by N is programmed as N minus one.
// [R15] Reference divider is four bits, oscillator divider five bits.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module data_sync_window_shift_control
  import dsync_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Analog side pins
  input  wire logic              raw_read_data,
  input  wire logic              osc_3x_pulse,
  input  wire logic              code_ref_pulse,
  input  wire logic              synth_osc_pulse,
  input  wire logic              freq_up_err,
  input  wire logic              freq_down_err,
  // Sequencer phase, same clock
  input  wire logic              acquiring,
  // Loop and synthesizer controls
  output logic [1:0]             loop_gain_band,
  output logic                   pd_gain_half,
  output logic                   filter_res_bypass,
  output logic                   synth_pump_up,
  output logic                   synth_pump_down,
  // Data path outputs
  output logic                   recovered_clock,
  output logic                   delayed_read_data,
  output logic                   detect_window_clock
);
  // Two-flop synchronisers plus an edge stage for the pins
  logic [5:0] sync1_reg, sync2_reg, sync3_reg;
  logic [5:0] pins;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  assign pins = {freq_down_err, freq_up_err, synth_osc_pulse,
                 code_ref_pulse, osc_3x_pulse, raw_read_data};
  logic osc_tick, ref_tick, wso_tick;
  assign osc_tick = sync2_reg[1] & ~sync3_reg[1];
  assign ref_tick = sync2_reg[2] & ~sync3_reg[2];
  assign wso_tick = sync2_reg[3] & ~sync3_reg[3];

  // Register file and AXI slave state
  logic [CFG_W-1:0]     cfg_reg, cfg_next;
  logic                 test_reg, test_next;
  logic [REF_DIV_W-1:0] ref_div_reg, ref_div_next;
  logic [OSC_DIV_W-1:0] osc_div_reg, osc_div_next;
  logic [AMP_W-1:0]     amp_reg, amp_next;
  logic                 aw_full_reg, aw_full_next;
  logic                 w_full_reg, w_full_next;
  logic [ADDR_W-1:0]    waddr_reg, waddr_next;
  logic [7:0]           wbyte_reg, wbyte_next;
  logic                 wstb_reg, wstb_next;
  logic                 bvalid_reg, bvalid_next;
  logic [1:0]           bresp_reg, bresp_next;
  logic                 rvalid_reg, rvalid_next;
  logic [1:0]           rresp_reg, rresp_next;
  logic [31:0]          rdata_reg, rdata_next;
  logic                 locked_reg;
  logic                 up_reg, down_reg;
  logic                 do_write, hit;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_arready = !rvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  // Address and data are caught separately, written once both are held
  always_comb begin
    cfg_next     = cfg_reg;
    test_next    = test_reg;
    ref_div_next = ref_div_reg;
    osc_div_next = osc_div_reg;
    amp_next     = amp_reg;
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    waddr_next   = waddr_reg;
    wbyte_next   = wbyte_reg;
    wstb_next    = wstb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    hit          = 1'b1;
    if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      waddr_next   = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      wbyte_next  = s_axi_wdata[7:0];
      wstb_next   = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Divider loads are not blocked while enabled; software sequences it
    if (do_write) begin // [R10]
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      if (waddr_reg == CONFIG_OFS) begin
        if (wstb_reg) cfg_next = wbyte_reg[CFG_W-1:0];
      end else if (waddr_reg == TEST_OFS) begin
        if (wstb_reg) test_next = wbyte_reg[0];
      end else if (waddr_reg == REF_DIV_OFS) begin
        if (wstb_reg) ref_div_next = wbyte_reg[REF_DIV_W-1:0]; // [R15]
      end else if (waddr_reg == OSC_DIV_OFS) begin
        if (wstb_reg) osc_div_next = wbyte_reg[OSC_DIV_W-1:0]; // [R15]
      end else if (waddr_reg == AMP_OFS) begin
        if (wstb_reg) amp_next = wbyte_reg[AMP_W-1:0];
      end else if (waddr_reg != STATUS_OFS) begin
        hit = 1'b0;
      end
      bresp_next = hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    // Read answer one cycle after the address is taken
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (s_axi_araddr == CONFIG_OFS) begin
        rdata_next[CFG_W-1:0] = cfg_reg;
      end else if (s_axi_araddr == TEST_OFS) begin
        rdata_next[0] = test_reg;
      end else if (s_axi_araddr == REF_DIV_OFS) begin
        rdata_next[REF_DIV_W-1:0] = ref_div_reg;
      end else if (s_axi_araddr == OSC_DIV_OFS) begin
        rdata_next[OSC_DIV_W-1:0] = osc_div_reg;
      end else if (s_axi_araddr == AMP_OFS) begin
        rdata_next[AMP_W-1:0] = amp_reg;
      end else if (s_axi_araddr == STATUS_OFS) begin
        rdata_next[3:0] = {acquiring, down_reg, up_reg, locked_reg};
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_reg     <= CFG_RST;
      test_reg    <= 1'b0;
      ref_div_reg <= REF_DIV_RST;
      osc_div_reg <= OSC_DIV_RST;
      amp_reg     <= AMP_RST;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      waddr_reg   <= '0;
      wbyte_reg   <= 8'h00;
      wstb_reg    <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      cfg_reg     <= cfg_next;
      test_reg    <= test_next;
      ref_div_reg <= ref_div_next;
      osc_div_reg <= osc_div_next;
      amp_reg     <= amp_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      waddr_reg   <= waddr_next;
      wbyte_reg   <= wbyte_next;
      wstb_reg    <= wstb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  logic wss_en;
  assign wss_en = cfg_reg[WSS_EN_BIT];

  // Recovered clock: 3x oscillator divided by three
  logic rec_pulse;
  ratio_divider #(.W(2)) u_div3 (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (1'b1),
    .tick    (osc_tick),
    .ratio   (DIV3_RATIO), // [R1]
    .pulse   (rec_pulse)
  );
  assign recovered_clock = rec_pulse;

  // Synthesizer dividers divide by value plus one
  logic ref_p, osc_p;
  ratio_divider #(.W(REF_DIV_W)) u_ref_div (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (wss_en),
    .tick    (ref_tick),
    .ratio   (ref_div_reg), // [R9] [R14]
    .pulse   (ref_p)
  );
  ratio_divider #(.W(OSC_DIV_W)) u_osc_div (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (wss_en),
    .tick    (wso_tick),
    .ratio   (osc_div_reg), // [R9] [R14]
    .pulse   (osc_p)
  );

  // Phase-frequency detector and lock counter on the divided edges
  logic       up_next, down_next, locked_next;
  logic [3:0] hits_reg, hits_next;
  always_comb begin
    up_next     = up_reg | ref_p; // [R9]
    down_next   = down_reg | osc_p;
    hits_next   = hits_reg;
    if (up_next && down_next) begin
      up_next   = 1'b0;
      down_next = 1'b0;
    end
    if (ref_p && osc_p) begin
      if (hits_reg != LOCK_HITS) hits_next = hits_reg + 4'h1;
    end else if (ref_p || osc_p) begin
      hits_next = 4'h0;
    end
    if (!wss_en) begin
      up_next   = 1'b0;
      down_next = 1'b0;
      hits_next = 4'h0;
    end
    locked_next = (hits_next == LOCK_HITS);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      up_reg     <= 1'b0;
      down_reg   <= 1'b0;
      hits_reg   <= 4'h0;
      locked_reg <= 1'b0;
    end else begin
      up_reg     <= up_next;
      down_reg   <= down_next;
      hits_reg   <= hits_next;
      locked_reg <= locked_next;
    end
  end
  assign synth_pump_up   = up_reg;
  assign synth_pump_down = down_reg;

  // Percent shift tap around the window center
  logic [3:0] pws_tap, wss_tap;
  always_comb begin
    pws_tap = PWS_CENTER_TAP;
    if (cfg_reg[PWS_EN_BIT]) begin // [R6]
      if (cfg_reg[PWS_DIR_BIT]) begin
        pws_tap = PWS_CENTER_TAP + (PWS_STEP_TAP << cfg_reg[PWS_SIZE_BIT]);
      end else begin
        pws_tap = PWS_CENTER_TAP - (PWS_STEP_TAP << cfg_reg[PWS_SIZE_BIT]);
      end
    end
    // Stage count is select plus one; disabled means a single stage
    wss_tap = wss_en ? amp_reg : 4'h0; // [R8] [R11]
  end

  // Independent lines so both shifts act at once
  logic shifted_data, shifted_win;
  tap_delay_line #(.DEPTH(16), .SEL_W(4)) u_pws_line (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (sync2_reg[0]),
    .sel     (pws_tap), // [R7]
    .q       (shifted_data)
  );
  tap_delay_line #(.DEPTH(16), .SEL_W(4)) u_wss_line (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (rec_pulse),
    .sel     (wss_tap), // [R7]
    .q       (shifted_win)
  );

  // Band, gain and monitor outputs, all registered
  logic [1:0] band_reg, band_next;
  logic       half_reg, half_next, byp_reg, byp_next;
  logic       mon_d_reg, mon_d_next, mon_w_reg, mon_w_next;
  always_comb begin
    band_next  = {cfg_reg[BAND_HI_BIT], cfg_reg[BAND_LO_BIT]}; // [R2]
    half_next  = acquiring; // [R3]
    byp_next   = acquiring; // [R3]
    mon_d_next = 1'b0;
    mon_w_next = 1'b0;
    if (cfg_reg[WINDOW_MONITOR_ENABLE_BIT]) begin // [R4]
      if (test_reg) begin
        mon_d_next = sync2_reg[4]; // [R5]
        mon_w_next = sync2_reg[5]; // [R5]
      end else begin
        mon_d_next = shifted_data;
        mon_w_next = shifted_win;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      band_reg  <= 2'h0;
      half_reg  <= 1'b0;
      byp_reg   <= 1'b0;
      mon_d_reg <= 1'b0;
      mon_w_reg <= 1'b0;
    end else begin
      band_reg  <= band_next;
      half_reg  <= half_next;
      byp_reg   <= byp_next;
      mon_d_reg <= mon_d_next;
      mon_w_reg <= mon_w_next;
    end
  end
  assign loop_gain_band      = band_reg;
  assign pd_gain_half        = half_reg;
  assign filter_res_bypass   = byp_reg;
  assign delayed_read_data   = mon_d_reg;
  assign detect_window_clock = mon_w_reg;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_monitor_held_low: assert property ( // [R4]
    !cfg_reg[WINDOW_MONITOR_ENABLE_BIT] |=> !delayed_read_data && !detect_window_clock)
    else $error("monitor outputs not low while disabled");
  a_mux_up_err: assert property ( // [R5]
    cfg_reg[WINDOW_MONITOR_ENABLE_BIT] && test_reg && sync2_reg[4] |=> delayed_read_data)
    else $error("frequency-up error not on data pin");
  a_mux_down_err: assert property ( // [R5]
    cfg_reg[WINDOW_MONITOR_ENABLE_BIT] && test_reg && !sync2_reg[5] |=> !detect_window_clock)
    else $error("frequency-down error not on window pin");
  a_recovered_rate: assert property ( // [R1]
    rec_pulse |=> !rec_pulse [*5])
    else $error("recovered clock faster than a third");
  a_band_follow: assert property ( // [R2]
    ##1 loop_gain_band == $past({cfg_reg[BAND_HI_BIT], cfg_reg[BAND_LO_BIT]}))
    else $error("band output does not follow config");
  a_acq_gain_half: assert property ( // [R3]
    ##1 pd_gain_half == $past(acquiring) && filter_res_bypass == $past(acquiring))
    else $error("gain or filter setting wrong for loop phase");
  a_pws_late_big: assert property ( // [R6]
    cfg_reg[PWS_EN_BIT] && cfg_reg[PWS_DIR_BIT] && cfg_reg[PWS_SIZE_BIT]
      |-> pws_tap == 4'hA)
    else $error("large late shift tap wrong");
  a_synth_off_idle: assert property ( // [R8]
    !wss_en |-> wss_tap == 4'h0 ##1 (!locked_reg && !synth_pump_up && !synth_pump_down))
    else $error("synthesizer active while disabled");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_synth_lock: cover property (locked_reg && wss_en);
  c_mux_test: cover property (test_reg && delayed_read_data);
endmodule

// [verilog/dsync_pkg.sv]
package dsync_pkg;
  // Register byte offsets
  localparam logic [7:0] CONFIG_OFS   = 8'h00;
  localparam logic [7:0] TEST_OFS     = 8'h04;
  localparam logic [7:0] REF_DIV_OFS  = 8'h08;
  localparam logic [7:0] OSC_DIV_OFS  = 8'h0C;
  localparam logic [7:0] AMP_OFS      = 8'h10;
  localparam logic [7:0] STATUS_OFS   = 8'h14;
  // Configuration field positions
  localparam int BAND_LO_BIT  = 0;
  localparam int BAND_HI_BIT  = 1;
  localparam int WINDOW_MONITOR_ENABLE_BIT     = 2;
  localparam int PWS_EN_BIT   = 3;
  localparam int PWS_DIR_BIT  = 4;
  localparam int PWS_SIZE_BIT = 5;
  localparam int WSS_EN_BIT   = 6;
  localparam int CFG_W        = 7;
  // Field widths and reset values
  localparam int REF_DIV_W = 4;
  localparam int OSC_DIV_W = 5;
  localparam int AMP_W     = 4;
  localparam logic [6:0] CFG_RST     = 7'h00;
  localparam logic [3:0] REF_DIV_RST = 4'h0;
  localparam logic [4:0] OSC_DIV_RST = 5'h00;
  localparam logic [3:0] AMP_RST     = 4'h0;
  // Recovered clock divides the 3x oscillator by three (value N-1)
  localparam logic [1:0] DIV3_RATIO = 2'h2;
  // Percent shift taps: sixteen taps span one code window
  localparam logic [3:0] PWS_CENTER_TAP = 4'h8;
  localparam logic [3:0] PWS_STEP_TAP   = 4'h1;
  // Coincident divided edges before the synthesizer reports lock
  localparam logic [3:0] LOCK_HITS = 4'h8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [verilog/ratio_divider.sv]
`timescale 1ns/100ps
module ratio_divider
  import dsync_pkg::*;
#(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Count control
  input  wire logic         enable,
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  // One pulse per ratio+1 ticks
  output logic              pulse
);
  logic [W-1:0] count_reg, count_next;
  logic         pulse_reg, pulse_next;

  // Count ticks; a disabled divider rests at zero
  always_comb begin
    count_next = count_reg;
    pulse_next = 1'b0;
    if (!enable) begin
      count_next = '0;
    end else if (tick) begin
      if (count_reg >= ratio) begin
        count_next = '0;
        pulse_next = 1'b1;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse = pulse_reg;
endmodule

// [verilog/tap_delay_line.sv]
`timescale 1ns/100ps
module tap_delay_line #(
  parameter int DEPTH = 16,
  parameter int SEL_W = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Line input and tap choice
  input  wire logic             d,
  input  wire logic [SEL_W-1:0] sel,
  // Registered tap output
  output logic                  q
);
  logic [DEPTH-1:0] line_reg, line_next;
  logic             q_reg, q_next;

  // Shift one stage per clock; tap 0 is one stage deep
  always_comb begin
    line_next = {line_reg[DEPTH-2:0], d};
    q_next    = line_reg[sel];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      line_reg <= '0;
      q_reg    <= 1'b0;
    end else begin
      line_reg <= line_next;
      q_reg    <= q_next;
    end
  end

  assign q = q_reg;
endmodule
